// >>> mrat_pkg.sv
// Shared constants for the mode register access timing pair.
// Assumes one 10 MHz command clock shared by controller and DRAM end.
package mrat_pkg;
  // Clock and analog minima
  localparam int CK_PERIOD_NS = 100;
  localparam int T_MRW_NS = 10;
  localparam int T_MRD_NS = 14;
  localparam int T_GUARD_PS = 7500;
  localparam int MRW_MIN_NCK = 10;
  localparam int MRD_MIN_NCK = 10;
  localparam int GUARD_MIN_NCK = 8;
  localparam int MRR_NCK = 8;
  localparam int PDX_EXTRA_NCK = 3;
  localparam int MRR_MRW_EXTRA = 3;
  localparam int RDA_RTP_OFFS = 8;

  // Device timing figures in clock cycles (plain defaults)
  localparam int BL = 16;
  localparam int RL = 14;
  localparam int WL = 8;
  localparam int DQSCK_RU = 1;
  localparam int RPST_RD = 0;
  localparam int WPRE = 2;
  localparam int ODTLON = 4;
  localparam int ODTON_RD = 0;
  localparam int WTR_RU = 1;
  localparam int RCD = 1;
  localparam int XP = 1;
  localparam int NRTP = 8;
  localparam int NWR = 6;

  localparam int MRW_NS_CYC = (T_MRW_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int MRD_NS_CYC = (T_MRD_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int GUARD_NS_CYC =
    (T_GUARD_PS + CK_PERIOD_NS * 1000 - 1) / (CK_PERIOD_NS * 1000);
  localparam int TMRW = (MRW_NS_CYC > MRW_MIN_NCK) ? MRW_NS_CYC : MRW_MIN_NCK;
  localparam int TMRD = (MRD_NS_CYC > MRD_MIN_NCK) ? MRD_NS_CYC : MRD_MIN_NCK;
  localparam int GUARD =
    (GUARD_NS_CYC > GUARD_MIN_NCK) ? GUARD_NS_CYC : GUARD_MIN_NCK;
  localparam int TMRW_BLK = (TMRW > TMRD) ? TMRW : TMRD;

  // Spacings from the issued command, in cycles
  localparam int RD_TO_MRR = BL / 2;
  localparam int WR_TO_MRR = WL + BL / 2 + 1 + WTR_RU;
  localparam int MRR_TO_WR_NOODT = RL + DQSCK_RU + BL / 2 - WL + WPRE + RPST_RD;
  localparam int MRR_TO_WR_ODT =
    RL + DQSCK_RU + BL / 2 - ODTLON - ODTON_RD + RPST_RD + 1;
  localparam int MRR_TO_MRW = RL + DQSCK_RU + BL / 2 + MRR_MRW_EXTRA;
  localparam int PDX_TO_MRR = XP + RCD + PDX_EXTRA_NCK;
  localparam int RD_TO_MRW = RL + BL / 2 + DQSCK_RU + RPST_RD + GUARD;
  localparam int RDA_TO_MRW = RD_TO_MRW + NRTP - RDA_RTP_OFFS;
  localparam int WR_TO_MRW = WL + 1 + BL / 2 + GUARD;
  localparam int WRA_TO_MRW = WR_TO_MRW + NWR;

  localparam int CNT_W = 8;
  localparam int CA_W = 6;
  localparam int MR_NUM = 64;
  localparam int BANKS = 8;
  localparam int BANK_W = 3;

  // Opcodes carried on the first beat of a command
  localparam logic [5:0] OP_RD = 6'h01;
  localparam logic [5:0] OP_RDA = 6'h02;
  localparam logic [5:0] OP_WR = 6'h03;
  localparam logic [5:0] OP_WRA = 6'h04;
  localparam logic [5:0] OP_MWR = 6'h05;
  localparam logic [5:0] OP_MWRA = 6'h06;
  localparam logic [5:0] OP_RDFIFO = 6'h07;
  localparam logic [5:0] OP_RDCAL = 6'h08;
  localparam logic [5:0] OP_WRFIFO = 6'h09;
  localparam logic [5:0] OP_MRR = 6'h0A;
  localparam logic [5:0] OP_MRW = 6'h0B;
  localparam logic [5:0] OP_ACT = 6'h0C;
  localparam logic [5:0] OP_PRE = 6'h0D;
  localparam logic [5:0] OP_NONE = 6'h00;

  typedef enum logic [3:0] {
    CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_MWR, CMD_MWRA, CMD_RDFIFO,
    CMD_RDCAL, CMD_WRFIFO, CMD_MRR, CMD_MRW, CMD_ACT, CMD_PRE, CMD_PDE,
    CMD_PDX
  } mrat_cmd_t;
endpackage

// >>> mrat_if.sv
// Command link between controller and DRAM end.
// Assumes both ends run on the same CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
interface mrat_if;
  logic cke;
  logic cs;
  logic [5:0] ca;
  logic dq_valid;
  logic [5:0] dq;
  modport ctrl (output cke, output cs, output ca, input dq_valid, input dq);
  modport dram (input cke, input cs, input ca, output dq_valid, output dq);
endinterface
`default_nettype wire

// >>> mrat_dram.sv
// DRAM end: captures commands, holds mode registers and bank state.
// Assumes the controller keeps every command spacing.
`timescale 1ns/1ps
`default_nettype none
module mrat_dram #(
  parameter logic [63:0] RO_MASK = 64'h0000000000000001
) (
  input wire logic CORE_CLK, // Command clock
  input wire logic RST_B, // Synchronous reset, active low
  mrat_if.dram LINK, // Command link
  output logic [7:0] BANK_OPEN, // Open bank per bit
  output logic MRW_IGNORED // Pulse: write to read-only dropped
);
  typedef enum {ST_CMD, ST_ARG, ST_DATA} mrat_dst_t;
  mrat_dst_t state_r;
  logic [5:0] op_r;
  logic [5:0] addr_r;
  logic [5:0] mr_r [mrat_pkg::MR_NUM];
  logic [7:0] bank_r;
  logic [mrat_pkg::CNT_W-1:0] rl_cnt_r;
  logic [5:0] rd_addr_r;
  logic dq_valid_r;
  logic [5:0] dq_r;
  logic take;
  logic [7:0] bank_bit;

  // Sample only with cke and cs
  assign take = LINK.cke && LINK.cs;
  assign bank_bit = 8'h01 << LINK.ca[mrat_pkg::BANK_W-1:0];

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      state_r <= ST_CMD;
      op_r <= mrat_pkg::OP_NONE;
      addr_r <= 6'h00;
    end
    else if (take)
    begin
      unique case (state_r)
        ST_CMD:
        begin
          op_r <= LINK.ca;
          state_r <= ST_ARG;
        end
        ST_ARG:
        begin
          addr_r <= LINK.ca;
          state_r <= (op_r == mrat_pkg::OP_MRW) ? ST_DATA : ST_CMD;
        end
        ST_DATA:
          state_r <= ST_CMD;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < mrat_pkg::MR_NUM; i++)
        mr_r[i] <= 6'h00;
      MRW_IGNORED <= 1'b0;
    end
    else
    begin
      MRW_IGNORED <= 1'b0;
      if (take && state_r == ST_DATA)
      begin
        if (RO_MASK[addr_r])
          MRW_IGNORED <= 1'b1;
        else
          mr_r[addr_r] <= LINK.ca;
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      bank_r <= 8'h00;
    else if (take && state_r == ST_ARG && op_r == mrat_pkg::OP_ACT)
      bank_r <= bank_r | bank_bit;
    else if (take && state_r == ST_ARG && op_r == mrat_pkg::OP_PRE)
      bank_r <= bank_r & ~bank_bit;
  end

  // Read data appears RL cycles after the MRR opcode beat
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      rl_cnt_r <= '0;
      rd_addr_r <= 6'h00;
      dq_valid_r <= 1'b0;
      dq_r <= 6'h00;
    end
    else
    begin
      dq_valid_r <= 1'b0;
      if (take && state_r == ST_CMD && LINK.ca == mrat_pkg::OP_MRR)
        rl_cnt_r <= mrat_pkg::CNT_W'(mrat_pkg::RL - 1);
      else if (rl_cnt_r != '0)
        rl_cnt_r <= rl_cnt_r - 1'b1;
      if (take && state_r == ST_ARG && op_r == mrat_pkg::OP_MRR)
        rd_addr_r <= LINK.ca;
      if (rl_cnt_r == mrat_pkg::CNT_W'(1))
      begin
        dq_valid_r <= 1'b1;
        dq_r <= mr_r[rd_addr_r];
      end
    end
  end

  assign LINK.dq_valid = dq_valid_r;
  assign LINK.dq = dq_r;
  assign BANK_OPEN = bank_r;
endmodule
`default_nettype wire

// >>> mrat_ctrl.sv
// Controller end: issues commands while enforcing mode register spacing.
// Assumes the DRAM end shares CORE_CLK; ODT_EN is a same-clock level.
`timescale 1ns/1ps
`default_nettype none
module mrat_ctrl (
  input wire logic CORE_CLK, // Command clock
  input wire logic RST_B, // Synchronous reset, active low
  mrat_if.ctrl LINK, // Command link
  input wire logic REQ_VALID, // Request present
  input wire mrat_pkg::mrat_cmd_t REQ_CMD, // Requested command
  input wire logic [5:0] REQ_ADDR, // Register or bank address
  input wire logic [5:0] REQ_DATA, // MRW data
  output logic REQ_READY, // Request taken this cycle
  input wire logic ODT_EN, // Data termination enabled
  output logic [5:0] MRR_DATA, // Last read mode register value
  output logic MRR_VALID, // Pulse: MRR_DATA updated
  output logic POWERED_DOWN // Clock enable held low
);
  typedef enum {ST_IDLE, ST_ARG, ST_DATA} mrat_cst_t;
  typedef logic [mrat_pkg::CNT_W-1:0] mrat_cnt_t;
  mrat_cst_t state_r;
  logic cke_r;
  logic cs_r;
  logic [5:0] ca_r;
  logic [5:0] arg_r;
  logic [5:0] data_r;
  logic is_mrw_r;
  mrat_cnt_t mrr_cnt_r, mrw_cnt_r, rd_cnt_r, wr_cnt_r, des_cnt_r;
  mrat_cnt_t mrr_nxt, mrw_nxt, rd_nxt, wr_nxt, des_nxt;
  logic [5:0] opcode;
  logic is_rd, is_wr, allowed, issue;
  int need_mrr, need_mrw, need_rd, need_wr, need_des;

  function automatic mrat_cnt_t next_cnt(mrat_cnt_t cur, int need);
    mrat_cnt_t dec;
    mrat_cnt_t req;
    dec = (cur == '0) ? '0 : cur - 1'b1;
    req = (need > 0) ? mrat_pkg::CNT_W'(need - 1) : '0;
    return (req > dec) ? req : dec;
  endfunction

  always_comb
  begin
    opcode = mrat_pkg::OP_NONE;
    unique case (REQ_CMD)
      mrat_pkg::CMD_RD: opcode = mrat_pkg::OP_RD;
      mrat_pkg::CMD_RDA: opcode = mrat_pkg::OP_RDA;
      mrat_pkg::CMD_WR: opcode = mrat_pkg::OP_WR;
      mrat_pkg::CMD_WRA: opcode = mrat_pkg::OP_WRA;
      mrat_pkg::CMD_MWR: opcode = mrat_pkg::OP_MWR;
      mrat_pkg::CMD_MWRA: opcode = mrat_pkg::OP_MWRA;
      mrat_pkg::CMD_RDFIFO: opcode = mrat_pkg::OP_RDFIFO;
      mrat_pkg::CMD_RDCAL: opcode = mrat_pkg::OP_RDCAL;
      mrat_pkg::CMD_WRFIFO: opcode = mrat_pkg::OP_WRFIFO;
      mrat_pkg::CMD_MRR: opcode = mrat_pkg::OP_MRR;
      mrat_pkg::CMD_MRW: opcode = mrat_pkg::OP_MRW;
      mrat_pkg::CMD_ACT: opcode = mrat_pkg::OP_ACT;
      mrat_pkg::CMD_PRE: opcode = mrat_pkg::OP_PRE;
      mrat_pkg::CMD_PDE: opcode = mrat_pkg::OP_NONE;
      mrat_pkg::CMD_PDX: opcode = mrat_pkg::OP_NONE;
      default: opcode = mrat_pkg::OP_NONE;
    endcase
  end

  assign is_rd = REQ_CMD inside {mrat_pkg::CMD_RD, mrat_pkg::CMD_RDA,
    mrat_pkg::CMD_RDFIFO, mrat_pkg::CMD_RDCAL};
  assign is_wr = REQ_CMD inside {mrat_pkg::CMD_WR, mrat_pkg::CMD_WRA,
    mrat_pkg::CMD_MWR, mrat_pkg::CMD_MWRA, mrat_pkg::CMD_WRFIFO};

  // FIFO read and calibration read are gated by rd_cnt as well: the
  // MRR-to-read spacing applies to every read kind, kept simple here.
  always_comb
  begin
    allowed = 1'b1;
    if (is_rd)
      allowed = (rd_cnt_r == '0);
    else if (is_wr)
      allowed = (wr_cnt_r == '0);
    else if (REQ_CMD == mrat_pkg::CMD_MRR)
      allowed = (mrr_cnt_r == '0);
    else if (REQ_CMD == mrat_pkg::CMD_MRW)
      allowed = (mrw_cnt_r == '0);
  end

  assign issue = (state_r == ST_IDLE) && REQ_VALID && (des_cnt_r == '0) &&
    allowed && (cke_r || REQ_CMD == mrat_pkg::CMD_PDX);
  assign REQ_READY = issue;

  always_comb
  begin
    need_mrr = 0;
    need_mrw = 0;
    need_rd = 0;
    need_wr = 0;
    need_des = 0;
    if (issue)
    begin
      unique case (REQ_CMD)
        mrat_pkg::CMD_RD, mrat_pkg::CMD_RDFIFO, mrat_pkg::CMD_RDCAL:
        begin
          need_mrr = mrat_pkg::RD_TO_MRR;
          need_mrw = mrat_pkg::RD_TO_MRW;
        end
        mrat_pkg::CMD_RDA:
        begin
          need_mrr = mrat_pkg::RD_TO_MRR;
          need_mrw = mrat_pkg::RDA_TO_MRW;
        end
        // Write to MRR, tWTR after strobe
        mrat_pkg::CMD_WR, mrat_pkg::CMD_MWR, mrat_pkg::CMD_WRFIFO:
        begin
          need_mrr = mrat_pkg::WR_TO_MRR;
          need_mrw = mrat_pkg::WR_TO_MRW;
        end
        mrat_pkg::CMD_WRA, mrat_pkg::CMD_MWRA:
        begin
          need_mrr = mrat_pkg::WR_TO_MRR;
          need_mrw = mrat_pkg::WRA_TO_MRW;
        end
        mrat_pkg::CMD_MRR:
        begin
          need_des = mrat_pkg::MRR_NCK;
          need_mrr = mrat_pkg::MRR_NCK;
          need_rd = mrat_pkg::MRR_NCK;
          need_wr = ODT_EN ? mrat_pkg::MRR_TO_WR_ODT :
            mrat_pkg::MRR_TO_WR_NOODT;
          need_mrw = mrat_pkg::MRR_TO_MRW;
        end
        mrat_pkg::CMD_MRW:
        begin
          need_des = mrat_pkg::TMRW_BLK;
          need_mrw = mrat_pkg::TMRW;
          need_mrr = mrat_pkg::TMRD;
          need_rd = mrat_pkg::TMRD;
          need_wr = mrat_pkg::TMRD;
        end
        mrat_pkg::CMD_PDX:
          need_mrr = mrat_pkg::PDX_TO_MRR;
        default:
          need_mrr = 0;
      endcase
    end
    mrr_nxt = next_cnt(mrr_cnt_r, need_mrr);
    mrw_nxt = next_cnt(mrw_cnt_r, need_mrw);
    rd_nxt = next_cnt(rd_cnt_r, need_rd);
    wr_nxt = next_cnt(wr_cnt_r, need_wr);
    des_nxt = next_cnt(des_cnt_r, need_des);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      mrr_cnt_r <= '0;
      mrw_cnt_r <= '0;
      rd_cnt_r <= '0;
      wr_cnt_r <= '0;
      des_cnt_r <= '0;
    end
    else
    begin
      mrr_cnt_r <= mrr_nxt;
      mrw_cnt_r <= mrw_nxt;
      rd_cnt_r <= rd_nxt;
      wr_cnt_r <= wr_nxt;
      des_cnt_r <= des_nxt;
    end
  end

  // Beats: opcode, address, then MRW data
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      state_r <= ST_IDLE;
      cs_r <= 1'b0;
      ca_r <= 6'h00;
      arg_r <= 6'h00;
      data_r <= 6'h00;
      is_mrw_r <= 1'b0;
    end
    else
    begin
      cs_r <= 1'b0;
      ca_r <= 6'h00;
      unique case (state_r)
        ST_IDLE:
          if (issue && opcode != mrat_pkg::OP_NONE)
          begin
            cs_r <= 1'b1;
            ca_r <= opcode;
            arg_r <= REQ_ADDR;
            data_r <= REQ_DATA;
            is_mrw_r <= (REQ_CMD == mrat_pkg::CMD_MRW);
            state_r <= ST_ARG;
          end
        ST_ARG:
        begin
          cs_r <= 1'b1;
          ca_r <= arg_r;
          state_r <= is_mrw_r ? ST_DATA : ST_IDLE;
        end
        ST_DATA:
        begin
          cs_r <= 1'b1;
          ca_r <= data_r;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      cke_r <= 1'b1;
    else if (issue && REQ_CMD == mrat_pkg::CMD_PDE)
      cke_r <= 1'b0;
    else if (issue && REQ_CMD == mrat_pkg::CMD_PDX)
      cke_r <= 1'b1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      MRR_DATA <= 6'h00;
      MRR_VALID <= 1'b0;
    end
    else
    begin
      MRR_VALID <= LINK.dq_valid;
      if (LINK.dq_valid)
        MRR_DATA <= LINK.dq;
    end
  end

  assign LINK.cke = cke_r;
  assign LINK.cs = cs_r;
  assign LINK.ca = ca_r;
  assign POWERED_DOWN = ~cke_r;
endmodule
`default_nettype wire

// >>> mrat_assertions.sv
// Spacing checker for the controller to DRAM command link.
// Assumes it watches the shared link signals on CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
module mrat_assertions (
  input wire logic CORE_CLK, // Command clock
  input wire logic RST_B, // Synchronous reset, active low
  input wire logic cke, // Clock enable
  input wire logic cs, // Beat valid
  input wire logic [5:0] ca, // Beat payload
  input wire logic dq_valid, // Read data valid
  input wire logic [5:0] dq // Read data
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic [1:0] rem_r;
  logic [7:0] mrr_r, mrw_r, rd_r, wr_r, pdx_r;
  logic op, is_mrr, is_mrw, is_rd, is_wr;
  assign op = cs && (rem_r == 2'h0);
  assign is_mrr = op && (ca == mrat_pkg::OP_MRR);
  assign is_mrw = op && (ca == mrat_pkg::OP_MRW);
  assign is_rd = op && (ca inside {mrat_pkg::OP_RD, mrat_pkg::OP_RDA,
    mrat_pkg::OP_RDFIFO, mrat_pkg::OP_RDCAL});
  assign is_wr = op && (ca inside {mrat_pkg::OP_WR, mrat_pkg::OP_WRA,
    mrat_pkg::OP_MWR, mrat_pkg::OP_MWRA, mrat_pkg::OP_WRFIFO});

  // Saturate so old history never wraps into a false gap
  function automatic logic [7:0] step(input logic [7:0] c, input logic ev);
    step = ev ? 8'h01 : ((c == 8'hFF) ? c : c + 8'h01);
  endfunction

  // Beat position: opcode, then one or two argument beats
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      rem_r <= 2'h0;
    else if (op)
      rem_r <= (ca == mrat_pkg::OP_MRW) ? 2'h2 : 2'h1;
    else if (cs)
      rem_r <= rem_r - 2'h1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      mrr_r <= 8'hFF;
      mrw_r <= 8'hFF;
      rd_r <= 8'hFF;
      wr_r <= 8'hFF;
      pdx_r <= 8'hFF;
    end
    else
    begin
      mrr_r <= step(mrr_r, is_mrr);
      mrw_r <= step(mrw_r, is_mrw);
      rd_r <= step(rd_r, is_rd);
      wr_r <= step(wr_r, is_wr);
      pdx_r <= step(pdx_r, cke && !$past(cke));
    end
  end

  chk_rd_mrr_gap: assert property (
    is_mrr |-> rd_r >= 8'(mrat_pkg::RD_TO_MRR))
    else $error("MRR too soon after read");
  chk_wr_mrr_gap: assert property (
    is_mrr |-> wr_r >= 8'(mrat_pkg::WR_TO_MRR))
    else $error("MRR too soon after write");
  chk_mrr_desel: assert property (
    (mrr_r > 8'h01 && mrr_r < 8'(mrat_pkg::MRR_NCK)) |-> !cs)
    else $error("Beat inside MRR period");
  chk_mrr_gap: assert property (
    (is_mrr || is_rd) |-> mrr_r >= 8'(mrat_pkg::MRR_NCK))
    else $error("MRR or read too soon after MRR");
  // Wake is seen one edge after the exit, like an opcode beat
  chk_pdx_mrr: assert property (
    is_mrr |-> pdx_r >= 8'(mrat_pkg::PDX_TO_MRR))
    else $error("MRR too soon after wake");
  chk_mrw_mrw: assert property (is_mrw |-> mrw_r >= 8'(mrat_pkg::TMRW))
    else $error("MRW too soon after MRW");
  chk_mrw_other: assert property ((is_mrr || is_rd || is_wr) |->
    mrw_r >= 8'(mrat_pkg::TMRD))
    else $error("Access too soon after MRW");
  chk_mrw_desel: assert property (
    (mrw_r > 8'h02 && mrw_r < 8'(mrat_pkg::TMRW_BLK)) |-> !cs)
    else $error("Beat inside MRW period");
  chk_mrr_wr_gap: assert property (is_wr |->
    mrr_r >= 8'(mrat_pkg::MRR_TO_WR_NOODT))
    else $error("Write too soon after MRR");
  chk_mrr_mrw: assert property (
    is_mrw |-> mrr_r >= 8'(mrat_pkg::MRR_TO_MRW))
    else $error("MRW too soon after MRR");
  chk_rd_mrw: assert property (
    is_mrw |-> rd_r >= 8'(mrat_pkg::RD_TO_MRW))
    else $error("MRW too soon after read");
  chk_wr_mrw: assert property (
    is_mrw |-> wr_r >= 8'(mrat_pkg::WR_TO_MRW))
    else $error("MRW too soon after write");
endmodule
`default_nettype wire

// >>> mrat_bench.sv
// Self-checking bench joining controller and DRAM end over the link.
// Assumes one 10 MHz clock; stimulus changes on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mrat_bench;
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic req_valid = 1'b0;
  mrat_pkg::mrat_cmd_t req_cmd = mrat_pkg::CMD_RD;
  logic [5:0] req_addr = 6'h00;
  logic [5:0] req_data = 6'h00;
  logic odt_en = 1'b0;
  logic req_ready, mrr_valid, powered_down, mrw_ignored;
  logic [5:0] mrr_data;
  logic [7:0] bank_open;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int ign_cnt = 0;
  int t_take = 0;
  mrat_if link();
  mrat_ctrl u_mrat_ctrl (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .LINK(link),
    .REQ_VALID(req_valid), .REQ_CMD(req_cmd), .REQ_ADDR(req_addr),
    .REQ_DATA(req_data), .REQ_READY(req_ready), .ODT_EN(odt_en),
    .MRR_DATA(mrr_data), .MRR_VALID(mrr_valid),
    .POWERED_DOWN(powered_down));
  mrat_dram u_mrat_dram (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .LINK(link),
    .BANK_OPEN(bank_open), .MRW_IGNORED(mrw_ignored));
  mrat_assertions u_mrat_assertions (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
    .cke(link.cke), .cs(link.cs), .ca(link.ca), .dq_valid(link.dq_valid),
    .dq(link.dq));

  always #50 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    if (mrw_ignored === 1'b1)
      ign_cnt <= ign_cnt + 1;
  end

  task automatic give_verdict();
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Select 0 waits on request ready, 1 on read data valid
  task automatic wait_hi(input logic sel, input int lim);
    int n;
    n = 0;
    while ((sel ? mrr_valid : req_ready) !== 1'b1)
    begin
      @(negedge CORE_CLK);
      n++;
      if (n > lim)
      begin
        errors++;
        give_verdict();
      end
    end
  endtask

  // Take time is read at the falling edge, where the count is settled
  task automatic issue(input mrat_pkg::mrat_cmd_t cmd,
    input logic [5:0] addr, input logic [5:0] data);
    @(negedge CORE_CLK);
    req_valid = 1'b1;
    req_cmd = cmd;
    req_addr = addr;
    req_data = data;
    #1;
    wait_hi(1'b0, 200);
    t_take = cyc;
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    req_valid = 1'b0;
  endtask

  // Idle tail clears every spacing before the next pair
  task automatic pair(input mrat_pkg::mrat_cmd_t a,
    input mrat_pkg::mrat_cmd_t b, input logic odt, input int gap);
    int t0;
    // Termination is sampled when the first command is taken
    odt_en = odt;
    issue(a, 6'h05, 6'h15);
    t0 = t_take;
    issue(b, 6'h05, 6'h15);
    check(8'(t_take - t0), 8'(gap));
    repeat (40) @(negedge CORE_CLK);
  endtask

  initial
  begin
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RST_B = 1'b1;
    pair(mrat_pkg::CMD_RD, mrat_pkg::CMD_MRR, 1'b0,
      mrat_pkg::RD_TO_MRR);
    pair(mrat_pkg::CMD_WR, mrat_pkg::CMD_MRR, 1'b0,
      mrat_pkg::WR_TO_MRR);
    pair(mrat_pkg::CMD_MWRA, mrat_pkg::CMD_MRR, 1'b0,
      mrat_pkg::WR_TO_MRR);
    pair(mrat_pkg::CMD_MRR, mrat_pkg::CMD_MRR, 1'b0,
      mrat_pkg::MRR_NCK);
    pair(mrat_pkg::CMD_MRR, mrat_pkg::CMD_RD, 1'b0,
      mrat_pkg::MRR_NCK);
    pair(mrat_pkg::CMD_MRR, mrat_pkg::CMD_WR, 1'b0,
      mrat_pkg::MRR_TO_WR_NOODT);
    pair(mrat_pkg::CMD_MRR, mrat_pkg::CMD_MWR, 1'b1,
      mrat_pkg::MRR_TO_WR_ODT);
    pair(mrat_pkg::CMD_MRR, mrat_pkg::CMD_MRW, 1'b0,
      mrat_pkg::MRR_TO_MRW);
    pair(mrat_pkg::CMD_MRW, mrat_pkg::CMD_MRW, 1'b0,
      mrat_pkg::TMRW);
    pair(mrat_pkg::CMD_MRW, mrat_pkg::CMD_MRR, 1'b0,
      mrat_pkg::TMRD);
    pair(mrat_pkg::CMD_MRW, mrat_pkg::CMD_WRA, 1'b0,
      mrat_pkg::TMRD);
    pair(mrat_pkg::CMD_RD, mrat_pkg::CMD_MRW, 1'b0,
      mrat_pkg::RD_TO_MRW);
    pair(mrat_pkg::CMD_RDA, mrat_pkg::CMD_MRW, 1'b0,
      mrat_pkg::RDA_TO_MRW);
    pair(mrat_pkg::CMD_RDCAL, mrat_pkg::CMD_MRW, 1'b0,
      mrat_pkg::RD_TO_MRW);
    pair(mrat_pkg::CMD_RDFIFO, mrat_pkg::CMD_MRW, 1'b0,
      mrat_pkg::RD_TO_MRW);
    pair(mrat_pkg::CMD_WRFIFO, mrat_pkg::CMD_MRW, 1'b0,
      mrat_pkg::WR_TO_MRW);
    pair(mrat_pkg::CMD_WRA, mrat_pkg::CMD_MRW, 1'b0,
      mrat_pkg::WRA_TO_MRW);
    issue(mrat_pkg::CMD_PDE, 6'h00, 6'h00);
    repeat (2) @(negedge CORE_CLK);
    check({7'h00, powered_down}, 8'h01);
    pair(mrat_pkg::CMD_PDX, mrat_pkg::CMD_MRR, 1'b0,
      mrat_pkg::PDX_TO_MRR);
    check({7'h00, powered_down}, 8'h00);
    issue(mrat_pkg::CMD_ACT, 6'h03, 6'h00);
    issue(mrat_pkg::CMD_MRW, 6'h09, 6'h2A);
    issue(mrat_pkg::CMD_MRW, 6'h00, 6'h3F);
    issue(mrat_pkg::CMD_MRR, 6'h09, 6'h00);
    wait_hi(1'b1, 60);
    check({2'h0, mrr_data}, 8'h2A);
    issue(mrat_pkg::CMD_MRR, 6'h00, 6'h00);
    wait_hi(1'b1, 60);
    check({2'h0, mrr_data}, 8'h00);
    check(8'(ign_cnt), 8'h01);
    check(bank_open, 8'h08);
    issue(mrat_pkg::CMD_PRE, 6'h03, 6'h00);
    repeat (2) @(negedge CORE_CLK);
    check(bank_open, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
